// ### verilog/fls_protect.sv
// How it works
// R1: one lock bit per region; 16, 8 or 4 regions by flash size.
// R2: each region is 64 consecutive pages, 16 kbytes, with its own bit.
// R3: program or erase in a locked region is aborted and flags lock error.
// R4: set-lock and clear-lock commands set and clear one region bit.
// R5: a valid erase-pin operation clears every lock bit.
// R6: security bit set refuses debug and external programming accesses.
// R7: only the set-security command sets it; clear-security is refused.
// R8: security clears only from erase pin, after full flash erase completes.
// R9: with security clear, debug and external accesses are granted again.
// R10: the driver holds the erase pin high longer than 200 ms.
// R11: erase pin low or floating means no erase; normal running continues.
// R12: calibration bits are read-only and erase leaves them alone.
// R13: a factory 128-bit unique identifier is readable, never writable.
// R14: erase-pin operation leaves the unique identifier unchanged.
// R15: flash reads get the programmed number of wait states.
// R16: erase pin synchronised and must stay high the full hold time.
`include "fls_defs.svh"
module fls_protect
#(
   parameter int unsigned    ERASE_HOLD_CYC = `FLS_ERASE_HOLD_CYC,
   parameter fls_pkg::fls_size_t SIZE_SEL   = fls_pkg::FLS_SIZE_LARGE,
   // identifier and calibration defaults are arbitrary
   parameter logic [127:0]   UID_VALUE      = 128'h0123_4567_89AB_CDEF_FEDC_BA98_7654_3210,
   parameter logic [31:0]    CAL_VALUE      = 32'h0000_00A5
)
(
   input  wire logic          aclk,
   input  wire logic          aresetn,
   input  wire logic          ce,
   input  wire logic [7:0]    s_axi_awaddr,
   input  wire logic          s_axi_awvalid,
   output logic               s_axi_awready,
   input  wire logic [31:0]   s_axi_wdata,
   input  wire logic [3:0]    s_axi_wstrb,
   input  wire logic          s_axi_wvalid,
   output logic               s_axi_wready,
   output logic [1:0]         s_axi_bresp,
   output logic               s_axi_bvalid,
   input  wire logic          s_axi_bready,
   input  wire logic [7:0]    s_axi_araddr,
   input  wire logic          s_axi_arvalid,
   output logic               s_axi_arready,
   output logic [31:0]        s_axi_rdata,
   output logic [1:0]         s_axi_rresp,
   output logic               s_axi_rvalid,
   input  wire logic          s_axi_rready,
   input  wire logic [15:0]   nv_lock_in,
   input  wire logic          nv_sec_in,
   output logic [15:0]        lock_bits,
   output logic               security_bit,
   output logic               flash_prog_req,
   output logic               flash_erase_req,
   output logic               flash_erase_all_req,
   output logic [15:0]        flash_page,
   input  wire logic          flash_done,
   output logic               lock_error,
   input  wire logic          erase_pin,
   input  wire logic          dbg_req,
   output logic               dbg_grant,
   input  wire logic          ext_req,
   output logic               ext_grant,
   input  wire logic          rd_req,
   output logic               rd_ack
);
   import fls_pkg::*;

   // regions present for this flash size
   function automatic logic [15:0] region_mask(input fls_size_t sz);
      case (sz)
         FLS_SIZE_LARGE:  region_mask = 16'hFFFF;   // [R1]
         FLS_SIZE_MIDDLE: region_mask = 16'h00FF;   // [R1]
         FLS_SIZE_SMALL:  region_mask = 16'h000F;   // [R1]
         default:         region_mask = 16'hFFFF;
      endcase
   endfunction

   // region index of a page: 64 pages per region
   function automatic logic [9:0] region_of(input logic [15:0] pg);
      region_of = pg[15:`FLS_PAGES_LOG2];   // [R2]
   endfunction

   localparam logic [15:0] MASK = region_mask(SIZE_SEL);
   localparam logic [1:0]  RESP_OK  = 2'h0;
   localparam logic [1:0]  RESP_ERR = 2'h2;
   localparam logic [`FLS_HOLD_CNT_W-1:0] HOLD = ERASE_HOLD_CYC[`FLS_HOLD_CNT_W-1:0];

   fls_state_t                  state_r;
   logic                        load_r;
   logic [15:0]                 lock_r;
   logic                        sec_r;
   logic [`FLS_WAIT_W-1:0]      wait_r;
   logic                        lockerr_r;
   logic                        cmderr_r;
   logic                        aw_full_r;
   logic                        w_full_r;
   logic [7:0]                  awaddr_r;
   logic [31:0]                 wdata_r;
   logic [3:0]                  wstrb_r;
   logic                        bvalid_r;
   logic [1:0]                  bresp_r;
   logic                        rvalid_r;
   logic [31:0]                 rdata_r;
   logic [1:0]                  rresp_r;
   logic                        pin_s1_r;
   logic                        pin_s2_r;
   logic [`FLS_HOLD_CNT_W-1:0]  hold_r;
   logic                        armed_r;
   logic                        erase_pend_r;
   logic                        prog_r;
   logic                        erase_r;
   logic                        erall_r;
   logic [15:0]                 page_r;
   logic [`FLS_WAIT_W-1:0]      ws_cnt_r;

   logic        wr_go;
   logic        rd_go;
   logic        cmd_wr;
   logic [7:0]  cmd_code;
   logic [15:0] cmd_page;
   logic [9:0]  cmd_reg;
   logic        reg_ok;
   logic        reg_locked;
   logic        stat_rd;
   logic        set_lockerr;
   logic        set_cmderr;
   logic        hold_hit;
   logic [31:0] rd_mux;
   logic        rd_map;

   // bus handshakes; one write and one read at a time
   assign s_axi_awready = ~aw_full_r & ~bvalid_r;
   assign s_axi_wready  = ~w_full_r & ~bvalid_r;
   assign s_axi_arready = ~rvalid_r;
   assign s_axi_bvalid  = bvalid_r;
   assign s_axi_bresp   = bresp_r;
   assign s_axi_rvalid  = rvalid_r;
   assign s_axi_rdata   = rdata_r;
   assign s_axi_rresp   = rresp_r;
   assign wr_go = ce & aw_full_r & w_full_r & ~bvalid_r;
   assign rd_go = ce & s_axi_arvalid & ~rvalid_r;

   // command decode; full-word strobes needed so half a command never fires
   assign cmd_wr     = wr_go & (awaddr_r == `FLS_OFF_CMD) & (wstrb_r == 4'hF);
   assign cmd_code   = wdata_r[`FLS_CMD_CODE_MSB:`FLS_CMD_CODE_LSB];
   assign cmd_page   = wdata_r[`FLS_CMD_PAGE_MSB:`FLS_CMD_PAGE_LSB];
   assign cmd_reg    = region_of(cmd_page);
   assign reg_ok     = (cmd_reg < 10'(`FLS_MAX_LOCKS)) && MASK[cmd_reg[3:0]];
   assign reg_locked = reg_ok & lock_r[cmd_reg[3:0]];
   assign stat_rd    = rd_go & (s_axi_araddr == `FLS_OFF_STAT);

   // locked program or erase aborts with no array request
   assign set_lockerr = cmd_wr & (state_r == FLS_IDLE) & reg_locked
                        & ((cmd_code == FLS_CMD_PROG) | (cmd_code == FLS_CMD_ERASE));   // [R3]
   // busy, out of range, unknown or clear-security is refused
   assign set_cmderr = cmd_wr & ~set_lockerr & ((state_r != FLS_IDLE) | ~reg_ok
                       | (cmd_code == FLS_CMD_CLRSEC)                               // [R7]
                       | (cmd_code == 8'h00) | (cmd_code > FLS_CMD_CLRSEC));

   // bus write address and data latches, taken in either order
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_full_r <= 1'b0;
         w_full_r  <= 1'b0;
         awaddr_r  <= 8'h00;
         wdata_r   <= 32'h0000_0000;
         wstrb_r   <= 4'h0;
      end
      else if (ce)
      begin
         if (s_axi_awvalid & s_axi_awready)
         begin
            aw_full_r <= 1'b1;
            awaddr_r  <= s_axi_awaddr;
         end
         else if (wr_go)
            aw_full_r <= 1'b0;
         if (s_axi_wvalid & s_axi_wready)
         begin
            w_full_r <= 1'b1;
            wdata_r  <= s_axi_wdata;
            wstrb_r  <= s_axi_wstrb;
         end
         else if (wr_go)
            w_full_r <= 1'b0;
      end
   end

   // write response; only cmd and wait are writable
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         bvalid_r <= 1'b0;
         bresp_r  <= RESP_OK;
      end
      else if (ce)
      begin
         if (wr_go)
         begin
            bvalid_r <= 1'b1;
            bresp_r  <= ((awaddr_r == `FLS_OFF_CMD) | (awaddr_r == `FLS_OFF_WAIT))
                        ? RESP_OK : RESP_ERR;
         end
         else if (s_axi_bready)
            bvalid_r <= 1'b0;
      end
   end

   // read mux; calibration and identifier are constants, nothing writes them
   always_comb
   begin
      rd_mux = 32'h0000_0000;
      rd_map = 1'b1;
      case (s_axi_araddr)
         `FLS_OFF_CMD:  rd_mux = {16'h0000, page_r};
         `FLS_OFF_STAT: rd_mux = {29'h0, cmderr_r, lockerr_r, state_r == FLS_IDLE};
         `FLS_OFF_LOCK: rd_mux = {16'h0000, lock_r};
         `FLS_OFF_SEC:  rd_mux = {31'h0, sec_r};
         `FLS_OFF_WAIT: rd_mux = {28'h0, wait_r};
         `FLS_OFF_CAL:  rd_mux = CAL_VALUE;                    // [R12]
         `FLS_OFF_UID0: rd_mux = UID_VALUE[31:0];              // [R13] [R14]
         `FLS_OFF_UID1: rd_mux = UID_VALUE[63:32];             // [R13] [R14]
         `FLS_OFF_UID2: rd_mux = UID_VALUE[95:64];             // [R13] [R14]
         `FLS_OFF_UID3: rd_mux = UID_VALUE[127:96];            // [R13] [R14]
         default:       rd_map = 1'b0;
      endcase
   end

   // read data channel
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         rvalid_r <= 1'b0;
         rdata_r  <= 32'h0000_0000;
         rresp_r  <= RESP_OK;
      end
      else if (ce)
      begin
         if (rd_go)
         begin
            rvalid_r <= 1'b1;
            rdata_r  <= rd_mux;
            rresp_r  <= rd_map ? RESP_OK : RESP_ERR;
         end
         else if (s_axi_rready)
            rvalid_r <= 1'b0;
      end
   end

   // wait-state setting, low byte lane only
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         wait_r <= `FLS_WAIT_RST;
      else if (ce && wr_go && awaddr_r == `FLS_OFF_WAIT && wstrb_r[0])
         wait_r <= wdata_r[`FLS_WAIT_W-1:0];
   end

   // sticky errors; read of status clears, a new event wins over the clear
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         lockerr_r <= 1'b0;
         cmderr_r  <= 1'b0;
      end
      else if (ce)
      begin
         lockerr_r <= set_lockerr | (lockerr_r & ~stat_rd);   // [R3]
         cmderr_r  <= set_cmderr | (cmderr_r & ~stat_rd);
      end
   end
   assign lock_error = lockerr_r;   // [R3]

   // erase pin: two-stage synchroniser, then hold counter
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         pin_s1_r <= 1'b0;
         pin_s2_r <= 1'b0;
      end
      else if (ce)
      begin
         pin_s1_r <= erase_pin;   // [R16]
         pin_s2_r <= pin_s1_r;
      end
   end

   // fires once per assertion, only after more than the hold time high
   assign hold_hit = pin_s2_r & armed_r & (hold_r == HOLD);   // [R16]
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         hold_r  <= '0;
         armed_r <= 1'b1;
      end
      else if (ce)
      begin
         if (!pin_s2_r)
         begin
            hold_r  <= '0;     // [R11]
            armed_r <= 1'b1;   // [R11]
         end
         else if (hold_hit)
            armed_r <= 1'b0;
         else if (armed_r)
            hold_r <= hold_r + 1'b1;   // [R16]
      end
   end

   // command and full-erase sequencer
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         state_r      <= FLS_IDLE;
         erase_pend_r <= 1'b0;
         prog_r       <= 1'b0;
         erase_r      <= 1'b0;
         erall_r      <= 1'b0;
         page_r       <= 16'h0000;
      end
      else if (ce)
      begin
         prog_r  <= 1'b0;
         erase_r <= 1'b0;
         erall_r <= 1'b0;
         if (hold_hit)
            erase_pend_r <= 1'b1;
         case (state_r)
            FLS_IDLE:
            begin
               // pin erase has priority over a command in the same cycle
               if (erase_pend_r)
               begin
                  erase_pend_r <= 1'b0;
                  erall_r      <= 1'b1;
                  state_r      <= FLS_ERASE_ALL;
               end
               else if (cmd_wr && !set_lockerr && !set_cmderr &&
                        (cmd_code == FLS_CMD_PROG || cmd_code == FLS_CMD_ERASE))
               begin
                  page_r  <= cmd_page;
                  prog_r  <= cmd_code == FLS_CMD_PROG;
                  erase_r <= cmd_code == FLS_CMD_ERASE;
                  state_r <= FLS_BUSY;
               end
            end
            FLS_BUSY:
               if (flash_done)
                  state_r <= FLS_IDLE;
            FLS_ERASE_ALL:
               if (flash_done)
                  state_r <= FLS_IDLE;
            default:
               state_r <= FLS_IDLE;
         endcase
      end
   end
   assign flash_prog_req      = prog_r;
   assign flash_erase_req     = erase_r;
   assign flash_erase_all_req = erall_r;
   assign flash_page          = page_r;

   // nonvolatile lock and security bits, loaded once after reset release
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         load_r <= 1'b1;
         lock_r <= 16'h0000;
         sec_r  <= 1'b1;   // refuse debug until the stored value is known
      end
      else if (ce)
      begin
         load_r <= 1'b0;
         if (load_r)
         begin
            lock_r <= nv_lock_in & MASK;   // [R1]
            sec_r  <= nv_sec_in;
         end
         else if (state_r == FLS_ERASE_ALL && flash_done)
         begin
            lock_r <= 16'h0000;   // [R5]
            sec_r  <= 1'b0;       // [R8]
         end
         else if (cmd_wr && state_r == FLS_IDLE && !erase_pend_r && !set_cmderr)
         begin
            if (cmd_code == FLS_CMD_SETLOCK)
               lock_r[cmd_reg[3:0]] <= 1'b1;   // [R4]
            else if (cmd_code == FLS_CMD_CLRLOCK)
               lock_r[cmd_reg[3:0]] <= 1'b0;   // [R4]
            else if (cmd_code == FLS_CMD_SETSEC)
               sec_r <= 1'b1;   // [R7]
         end
      end
   end
   assign lock_bits    = lock_r;
   assign security_bit = sec_r;

   // outside access paths gated by the security bit
   assign dbg_grant = dbg_req & ~sec_r;   // [R6] [R9]
   assign ext_grant = ext_req & ~sec_r;   // [R6] [R9]

   // flash read wait states; ack after wait_r extra cycles
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         ws_cnt_r <= '0;
      else if (ce)
      begin
         if (!rd_req || rd_ack)
            ws_cnt_r <= '0;
         else
            ws_cnt_r <= ws_cnt_r + 1'b1;   // [R15]
      end
   end
   assign rd_ack = ce & rd_req & (ws_cnt_r == wait_r);   // [R15]
endmodule

// ### include/fls_defs.svh
`ifndef FLS_DEFS_SVH
`define FLS_DEFS_SVH
// register byte offsets
`define FLS_OFF_CMD      8'h00
`define FLS_OFF_STAT     8'h04
`define FLS_OFF_LOCK     8'h08
`define FLS_OFF_SEC      8'h0C
`define FLS_OFF_WAIT     8'h10
`define FLS_OFF_CAL      8'h14
`define FLS_OFF_UID0     8'h20
`define FLS_OFF_UID1     8'h24
`define FLS_OFF_UID2     8'h28
`define FLS_OFF_UID3     8'h2C
// command register fields
`define FLS_CMD_CODE_LSB 0
`define FLS_CMD_CODE_MSB 7
`define FLS_CMD_PAGE_LSB 8
`define FLS_CMD_PAGE_MSB 23
// status register fields
`define FLS_ST_READY     0
`define FLS_ST_LOCKERR   1
`define FLS_ST_CMDERR    2
// geometry
`define FLS_MAX_LOCKS    16
`define FLS_PAGES_LOG2   6
`define FLS_WAIT_W       4
// reset values
`define FLS_WAIT_RST     4'h0
// timing
`define FLS_ERASE_HOLD_MS  200
`define FLS_CLK_KHZ        100000
`define FLS_ERASE_HOLD_CYC (`FLS_ERASE_HOLD_MS * `FLS_CLK_KHZ)
`define FLS_HOLD_CNT_W     25
`endif

// ### include/fls_pkg.sv
package fls_pkg;
   // command codes written to the command register
   typedef enum logic [7:0] {
      FLS_CMD_PROG    = 8'h01,
      FLS_CMD_ERASE   = 8'h02,
      FLS_CMD_SETLOCK = 8'h03,
      FLS_CMD_CLRLOCK = 8'h04,
      FLS_CMD_SETSEC  = 8'h05,
      FLS_CMD_CLRSEC  = 8'h06
   } fls_cmd_t;
   // lock-region count selection
   typedef enum logic [1:0] {
      FLS_SIZE_LARGE  = 2'h0,
      FLS_SIZE_MIDDLE = 2'h1,
      FLS_SIZE_SMALL  = 2'h2
   } fls_size_t;
   typedef enum {FLS_IDLE, FLS_BUSY, FLS_ERASE_ALL} fls_state_t;
endpackage

// ### tb/fls_flash_model.sv
module fls_flash_model
(
   input  wire logic       aclk,
   input  wire logic       aresetn,
   input  wire logic       start,
   input  wire logic [7:0] lat,
   output logic            flash_done
);
   timeunit 1ns;
   timeprecision 1ps;
   int cnt_r;
   // one operation at a time; lat picks a prompt or a slow array
   always_ff @(posedge aclk)
   begin
      flash_done <= 1'b0;
      if (!aresetn) cnt_r <= 0;
      else if (start) cnt_r <= int'(lat) + 1;
      else if (cnt_r == 1)
      begin
         cnt_r <= 0;
         flash_done <= 1'b1;
      end
      else if (cnt_r != 0) cnt_r <= cnt_r - 1;
   end
endmodule

// ### tb/fls_protect_props.sv
module fls_protect_props
#(
   parameter int unsigned ERASE_HOLD_CYC = 20
)
(
   input wire logic        aclk,
   input wire logic        aresetn,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic [15:0] lock_bits,
   input wire logic        security_bit,
   input wire logic        flash_prog_req,
   input wire logic        flash_erase_req,
   input wire logic        flash_erase_all_req,
   input wire logic [15:0] flash_page,
   input wire logic        flash_done,
   input wire logic        lock_error,
   input wire logic        erase_pin,
   input wire logic        dbg_req,
   input wire logic        dbg_grant,
   input wire logic        ext_req,
   input wire logic        ext_grant,
   input wire logic        rd_req,
   input wire logic        rd_ack
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0]  up_r;
   int unsigned hi_r;
   logic        armed_r;
   logic        ebusy_r;
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   // storage load on the first edge out of reset may move lock and security
   always_ff @(posedge aclk)
   begin
      if (!aresetn) up_r <= 2'h0;
      else if (up_r != 2'h3) up_r <= up_r + 2'h1;
   end
   // raw pin high time; the design adds sync delay so this is a lower bound
   always_ff @(posedge aclk)
   begin
      if (!aresetn || !erase_pin) hi_r <= 0;
      else hi_r <= hi_r + 1;
      if (!aresetn || flash_erase_all_req) armed_r <= 1'b0;
      else if (hi_r >= ERASE_HOLD_CYC) armed_r <= 1'b1;
      if (!aresetn || flash_done) ebusy_r <= 1'b0;
      else if (flash_erase_all_req) ebusy_r <= 1'b1;
   end
   sequence s_erase_end;
      ebusy_r && flash_done;
   endsequence
   sequence s_region_cmd;
      flash_prog_req || flash_erase_req;
   endsequence
   a_dbg_gate: assert property (dbg_grant == (dbg_req && !security_bit))
      else $error("debug grant wrong");
   a_ext_gate: assert property (ext_grant == (ext_req && !security_bit))
      else $error("external grant wrong");
   a_locked_abort: assert property ($rose(lock_error) |-> !flash_prog_req && !flash_erase_req)
      else $error("locked command reached array");
   a_unlocked_req: assert property (s_region_cmd |-> !lock_bits[flash_page[9:6]]
      && flash_page[15:10] == 6'h00) else $error("request into locked region");
   a_erase_clears: assert property (s_erase_end |=> lock_bits == 16'h0000 && !security_bit)
      else $error("full erase left protection");
   a_sec_fall_src: assert property ($fell(security_bit) && up_r == 2'h3
      |-> $past(flash_done) && $past(ebusy_r)) else $error("security cleared without erase");
   a_lock_change: assert property (!$stable(lock_bits) && up_r == 2'h3
      |-> $rose(s_axi_bvalid) || $past(flash_done)) else $error("lock bits moved alone");
   a_erase_held: assert property (flash_erase_all_req |-> armed_r)
      else $error("erase without full hold");
   a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready
      |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
   a_rd_ack_req: assert property (rd_ack |-> rd_req)
      else $error("read ack without request");
endmodule
bind fls_protect fls_protect_props #(.ERASE_HOLD_CYC(ERASE_HOLD_CYC)) u_props
(
   .aclk, .aresetn, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .lock_bits, .security_bit,
   .flash_prog_req, .flash_erase_req, .flash_erase_all_req, .flash_page, .flash_done,
   .lock_error, .erase_pin, .dbg_req, .dbg_grant, .ext_req, .ext_grant, .rd_req, .rd_ack
);

// ### tb/tb.sv
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   import fls_pkg::*;
   localparam int unsigned  HOLD = 20;
   localparam logic [127:0] UID  = 128'h0F1E_2D3C_4B5A_6978_8796_A5B4_C3D2_E1F0; // arbitrary
   localparam logic [31:0]  CAL  = 32'h0000_005A;
   logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
   logic        s_axi_rready, security_bit, flash_prog_req, flash_erase_req, flash_done;
   logic        flash_erase_all_req, lock_error, erase_pin, dbg_req, dbg_grant, ext_req;
   logic        ext_grant, rd_req, rd_ack, nv_sec_in, sec_m;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic [3:0]  s_axi_wstrb, wv;
   logic [7:0]  s_axi_awaddr, s_axi_araddr, lat;
   logic [15:0] nv_lock_in, lock_bits, flash_page, lk, pg;
   logic [31:0] s_axi_wdata, s_axi_rdata, rd;
   int          fail_count = 0, samples_checked = 0, n_pulse = 0, n_eall = 0, n;
   fls_protect #(.ERASE_HOLD_CYC(HOLD), .UID_VALUE(UID), .CAL_VALUE(CAL)) u_dut
   (
      .aclk, .aresetn, .ce(1'b1), .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .nv_lock_in, .nv_sec_in, .lock_bits,
      .security_bit, .flash_prog_req, .flash_erase_req, .flash_erase_all_req, .flash_page,
      .flash_done, .lock_error, .erase_pin, .dbg_req, .dbg_grant, .ext_req, .ext_grant,
      .rd_req, .rd_ack
   );
   fls_flash_model u_flash
   (
      .aclk, .aresetn, .lat, .flash_done,
      .start(flash_prog_req | flash_erase_req | flash_erase_all_req)
   );
   initial
   begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end
   // count array requests so a refused command shows apart from an accepted one
   always @(posedge aclk)
   begin
      if (flash_prog_req === 1'b1 || flash_erase_req === 1'b1) n_pulse++;
      if (flash_erase_all_req === 1'b1) n_eall++;
   end
   task automatic test_done();
      $display("checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task automatic chk(input bit ok, input string m);
      samples_checked++;
      if (!ok)
      begin
         fail_count++;
         $display("ERROR t=%0t %s", $time, m);
      end
   endtask
   task automatic timeout();
      chk(1'b0, "wait limit reached");
      test_done();
   endtask
   // write: address and data offered together, each dropped once taken
   task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      bit ad, wd;
      int k;
      ad = 0;
      wd = 0;
      k = 0;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      forever
      begin
         @(posedge aclk);
         if (s_axi_bready === 1'b1 && s_axi_bvalid === 1'b1) break;
         if (++k > 40) timeout();
         if (s_axi_awready === 1'b1) ad = 1;
         if (s_axi_wready === 1'b1) wd = 1;
         s_axi_awvalid <= !ad;
         s_axi_wvalid <= !wd;
         // late random ready so the response has to stand
         if (ad && wd && $urandom_range(1) == 1) s_axi_bready <= 1'b1;
      end
      s_axi_bready <= 1'b0;
      chk(s_axi_bresp === er, "write response");
   endtask
   task automatic axr(input logic [7:0] a, input logic [1:0] er);
      bit ad;
      int k;
      ad = 0;
      k = 0;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      forever
      begin
         @(posedge aclk);
         if (s_axi_rready === 1'b1 && s_axi_rvalid === 1'b1) break;
         if (++k > 40) timeout();
         if (s_axi_arready === 1'b1) ad = 1;
         s_axi_arvalid <= !ad;
         if (ad && $urandom_range(1) == 1) s_axi_rready <= 1'b1;
      end
      s_axi_rready <= 1'b0;
      rd = s_axi_rdata;
      chk(s_axi_rresp === er, "read response");
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
      axr(a, 2'h0);
      chk(rd === e, "read value");
   endtask
   // issue a command, poll until idle, collect error bits along the way
   task automatic cmd(input logic [7:0] c, input logic [15:0] p, input logic [1:0] ee, int pl);
      logic [1:0] acc;
      int k, p0;
      acc = 2'h0;
      k = 0;
      p0 = n_pulse;
      axw(8'h00, {8'h00, p, c}, 2'h0);
      chk(lock_error === ee[0], "lock error line");
      do
      begin
         axr(8'h04, 2'h0);
         acc = acc | rd[2:1];
         if (++k > 40) timeout();
      end
      while (rd[0] !== 1'b1);
      chk(acc === ee && n_pulse - p0 == pl, "command outcome");
      chk(lock_bits === lk && {dbg_grant, ext_grant} === {2{!sec_m}}, "lock or grant state");
   endtask
   initial
   begin
      void'($urandom(74));
      nv_lock_in = 16'($urandom);
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
      {nv_sec_in, dbg_req, ext_req, erase_pin, rd_req} = 5'h1C;
      s_axi_wstrb = 4'hF;
      lat = 8'h01;
      aresetn = 1'b0;
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (2) @(posedge aclk);
      lk = nv_lock_in;
      sec_m = 1'b1;
      rdchk(8'h08, {16'h0, lk});
      rdchk(8'h0C, 32'h1);
      rdchk(8'h14, CAL);
      for (int i = 0; i < 4; i++) rdchk(8'(8'h20 + 4 * i), UID[32 * i +: 32]);
      axw(8'h14, 32'hFFFF_FFFF, 2'h2);
      axw(8'h20, 32'h0, 2'h2);
      axr(8'h40, 2'h2);
      chk(rd === 32'h0 && {dbg_grant, ext_grant} === 2'h0, "unmapped or grants");
      $display("test reset state done");
      for (int r = 0; r < 16; r++)
      begin
         pg = 16'(r * 64 + $urandom_range(63));
         lat <= 8'(r % 2 ? 1 : 12);
         lk[r] = 1'b1;
         cmd(FLS_CMD_SETLOCK, pg, 2'h0, 0);
         cmd(FLS_CMD_PROG, pg, 2'h1, 0);
         cmd(FLS_CMD_ERASE, pg, 2'h1, 0);
         lk[r] = 1'b0;
         cmd(FLS_CMD_CLRLOCK, 16'(r * 64 + 63), 2'h0, 0);
         cmd(FLS_CMD_PROG, pg, 2'h0, 1);
         chk(flash_page === pg, "page");
         cmd(FLS_CMD_ERASE, pg, 2'h0, 1);
      end
      cmd(FLS_CMD_PROG, 16'h0400, 2'h2, 0);
      cmd(8'h07, 16'h0000, 2'h2, 0);
      cmd(FLS_CMD_CLRSEC, 16'h0000, 2'h2, 0);
      lk[5] = 1'b1;
      cmd(FLS_CMD_SETLOCK, 16'd320, 2'h0, 0);
      $display("test lock regions done");
      n = n_eall;
      erase_pin <= 1'b1;
      repeat (HOLD - 4) @(posedge aclk);
      erase_pin <= 1'b0;
      repeat (HOLD + 10) @(posedge aclk);
      chk(n_eall == n && lock_bits === lk && security_bit === 1'b1, "short pin");
      erase_pin <= 1'b1;
      repeat (HOLD + 8) @(posedge aclk); // held past the minimum
      erase_pin <= 1'b0;
      for (int k = 0; security_bit !== 1'b0; k++)
      begin
         @(posedge aclk);
         if (k > 100) timeout();
      end
      lk = 16'h0000;
      sec_m = 1'b0;
      chk(n_eall == n + 1 && lock_bits === lk, "pin erase");
      chk({dbg_grant, ext_grant} === 2'h3, "grants after erase");
      {dbg_req, ext_req} <= 2'h1;
      @(posedge aclk);
      chk({dbg_grant, ext_grant} === 2'h1, "grants follow requests");
      rdchk(8'h14, CAL);
      for (int i = 0; i < 4; i++) rdchk(8'(8'h20 + 4 * i), UID[32 * i +: 32]);
      sec_m = 1'b1;
      cmd(FLS_CMD_SETSEC, 16'h0000, 2'h0, 0);
      $display("test erase pin done");
      for (int k = 0; k < 3; k++)
      begin
         wv = k == 0 ? 4'h0 : (k == 1 ? 4'($urandom_range(14, 1)) : 4'hF);
         axw(8'h10, {28'h0, wv}, 2'h0);
         rdchk(8'h10, {28'h0, wv});
         rd_req <= 1'b1;
         n = 0;
         do
         begin
            @(posedge aclk);
            if (rd_ack !== 1'b1 && ++n > 40) timeout();
         end
         while (rd_ack !== 1'b1);
         rd_req <= 1'b0;
         chk(n == int'(wv), "read wait states");
      end
      $display("test wait states done");
      test_done();
   end
endmodule
